// ---- bench/ppi_tgt_model.sv ----
// ppi_tgt_model: behavioural target on the primary bus
// assumes: pins resolved by the bench, pull-up on trdy
`timescale 1ns/1ns
module ppi_tgt_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// bus view
	input  wire logic        frame_n,
	input  wire logic        irdy_n,
	input  wire logic [3:0]  cbe_n,
	// control from bench
	input  wire logic [3:0]  waits,
	input  wire logic        bad_par,
	// target drive
	output logic             trdy_n,
	output logic             trdy_oe,
	output logic      [31:0] ad_o,
	output logic             ad_oe,
	output logic             par_o,
	output logic             par_oe
);
	logic       act;
	logic       wr;
	logic       rel;
	logic [3:0] w;
	logic [7:0] k;
	always @(posedge mclk) begin
		par_oe <= ad_oe;
		par_o  <= ^{ad_o, cbe_n} ^ bad_par;
		if (srst) begin
			act     <= 1'b0;
			rel     <= 1'b0;
			trdy_oe <= 1'b0;
			trdy_n  <= 1'b1;
			ad_oe   <= 1'b0;
			k       <= 8'h00;
		end else if (!act && !frame_n && irdy_n) begin
			act     <= 1'b1;
			wr      <= cbe_n[0];
			w       <= waits;
			trdy_oe <= 1'b1;
			trdy_n  <= 1'b1;
		end else if (act && frame_n == 1'b0 && irdy_n && trdy_n) begin
			wr <= cbe_n[0];
		end else if (act && !trdy_n && !irdy_n) begin
			trdy_n <= 1'b1;
			ad_oe  <= 1'b0;
			k      <= k + 8'h01;
			w      <= waits;
			act    <= ~frame_n;
			rel    <= frame_n;
		end else if (act && w != 4'h0) begin
			w <= w - 4'h1;
		end else if (act) begin
			trdy_n <= 1'b0;
			ad_oe  <= ~wr;
			ad_o   <= 32'h0000c000 + {24'h000000, k};
		end else if (rel) begin
			trdy_oe <= 1'b0;
			rel     <= 1'b0;
			k       <= 8'h00;
		end
	end
endmodule : ppi_tgt_model

// ---- bench/primary_pci_bus_interface_tb.sv ----
// primary_pci_bus_interface_tb: initiator rows, park, refusal, parity
// assumes: ppi_primary as dut, ppi_tgt_model as far-side target
`timescale 1ns/1ns
module primary_pci_bus_interface_tb;
	typedef struct {
		logic w; logic d; logic [3:0] c; logic [63:0] a;
		logic [7:0] b; logic [3:0] ws;
	} ppi_row_t;
	ppi_row_t rows [6] = '{
		'{1'b1, 1'b0, 4'h7, 64'h10, 8'h01, 4'h0},
		'{1'b1, 1'b0, 4'h7, 64'h20, 8'h03, 4'h1},
		'{1'b0, 1'b0, 4'h6, 64'h30, 8'h01, 4'h0},
		'{1'b0, 1'b0, 4'h6, 64'h40, 8'h04, 4'h2},
		'{1'b1, 1'b1, 4'h7, 64'h5_0000_0050, 8'h02, 4'h0},
		'{1'b0, 1'b1, 4'h6, 64'h6_0000_0060, 8'h01, 4'h1}};
	logic mclk = 0, srst = 1, gnt_n = 1, bad_par = 0;
	logic [31:0] ad, ad_out, m_ad, ad_l, ad_p, wi = 0, rdata, tgt_rdata = 0;
	logic [3:0] cbe_n, cbe_n_out, cbe_p, waits = 0, req_cmd = 0;
	logic par, par_out, m_par, par_l, ad_oe, cbe_oe, par_oe, m_ad_oe, m_par_oe;
	logic frame_n, frame_n_out, frame_oe, irdy_n, irdy_n_out, irdy_oe;
	logic trdy_n, trdy_n_out, trdy_oe, m_trdy, m_trdy_oe, fr_p, ir_p, ae_p;
	logic fo_p, io_p, req_valid = 0, req_write = 0, req_dual = 0, wdata_take;
	logic req_busy, rdata_valid, tgt_rd_active = 0, tgt_v = 0, par_err, dph;
	logic [63:0] req_addr = 0;
	logic [7:0] req_beats = 1, n, rn, pe;
	int n_errors = 0, compares = 0;
	assign ad = ad_oe ? ad_out : m_ad_oe ? m_ad : ~ad_l;
	assign cbe_n = cbe_oe ? cbe_n_out : ~cbe_p;
	assign par = par_oe ? par_out : m_par_oe ? m_par : ~par_l;
	assign frame_n = frame_oe ? frame_n_out : 1'b1;
	assign irdy_n = irdy_oe ? irdy_n_out : 1'b1;
	assign trdy_n = trdy_oe ? trdy_n_out : m_trdy_oe ? m_trdy : 1'b1;
	ppi_primary u_dut (.mclk(mclk), .srst(srst), .gnt_n(gnt_n),
		.ad_in(ad), .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_in(cbe_n),
		.cbe_n_out(cbe_n_out), .cbe_oe(cbe_oe), .par_in(par),
		.par_out(par_out), .par_oe(par_oe), .frame_n_in(frame_n),
		.frame_n_out(frame_n_out), .frame_oe(frame_oe), .irdy_n_in(irdy_n),
		.irdy_n_out(irdy_n_out), .irdy_oe(irdy_oe), .trdy_n_in(trdy_n),
		.trdy_n_out(trdy_n_out), .trdy_oe(trdy_oe), .req_valid(req_valid),
		.req_write(req_write), .req_dual(req_dual), .req_cmd(req_cmd),
		.req_addr(req_addr), .req_beats(req_beats),
		.wdata(32'h1000 + wi), .wbe_n(4'h5), .wdata_valid(1'b1),
		.wdata_take(wdata_take), .req_busy(req_busy), .rdata(rdata),
		.rdata_valid(rdata_valid), .tgt_rd_active(tgt_rd_active),
		.tgt_rdata(tgt_rdata), .tgt_rdata_valid(tgt_v), .par_err(par_err));
	ppi_tgt_model u_tgt (.mclk(mclk), .srst(srst), .frame_n(frame_n),
		.irdy_n(irdy_n), .cbe_n(cbe_n), .waits(waits), .bad_par(bad_par),
		.trdy_n(m_trdy), .trdy_oe(m_trdy_oe), .ad_o(m_ad), .ad_oe(m_ad_oe),
		.par_o(m_par), .par_oe(m_par_oe));
	initial begin
		forever #50 mclk = ~mclk;
	end
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	task automatic cyc(int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc
	always @(posedge mclk) begin
		ad_l  <= ad;
		par_l <= par;
		if (wdata_take) wi <= wi + 1;
	end
	always @(negedge mclk) begin
		if (!srst) begin
			chk("par_oe", ae_p, par_oe);
			if (par_oe) chk("par", ^{ad_p, cbe_p}, par_out);
			if (fo_p && !frame_oe) chk("frame rel", 1, fr_p);
			if (io_p && !irdy_oe) chk("irdy rel", 1, ir_p);
			if (!frame_n && fr_p) chk("addr", req_addr[31:0], ad);
			if (!frame_n && fr_p) chk("cmd", req_dual ? 4'hd : req_cmd, cbe_n);
			if (dph && req_dual) chk("addr hi", req_addr[63:32], ad);
			if (dph && req_dual) chk("cmd2", req_cmd, cbe_n);
			if (!irdy_n && !trdy_n) begin
				if (req_write) chk("wdata", 32'h1000 + n, ad);
				if (req_write) chk("be", 4'h5, cbe_n);
				n++;
			end
			if (rdata_valid) chk("rdata", 32'hc000 + rn, rdata);
			if (rdata_valid) rn++;
			if (par_err) pe++;
		end
		dph  = !frame_n && fr_p;
		ad_p = ad; cbe_p = cbe_n; ae_p = ad_oe; fr_p = frame_n; ir_p = irdy_n;
		fo_p = frame_oe; io_p = irdy_oe;
	end
	task automatic run(ppi_row_t r);
		int t;
		n = 0; rn = 0; wi = 0; t = 0;
		req_write = r.w; req_dual = r.d; req_cmd = r.c;
		req_addr = r.a; req_beats = r.b; waits = r.ws; req_valid = 1;
		while (!req_busy && t < 20) begin cyc(1); t++; end
		while (req_busy && t < 200) begin cyc(1); t++; end
		req_valid = 0;
		chk("busy done", 0, req_busy);
		cyc(3);
		chk("phases", r.b, n);
		chk("reads", r.w ? 8'h0 : r.b, rn);
	endtask : run
	initial begin
		#(60000 * 100);
		n_errors++;
		stop_test();
	end
	initial begin
		pe = 0;
		cyc(12);
		chk("oe rst", 0, {ad_oe, cbe_oe, par_oe, frame_oe, irdy_oe, trdy_oe});
		srst = 0;
		gnt_n = 0;
		foreach (rows[i]) run(rows[i]);
		cyc(4);
		chk("park", 37'h1_0000_0000 << 4, {ad_oe, ad_out, cbe_n_out});
		chk("park par", 1, par_oe);
		bad_par = 1;
		run(rows[3]);
		bad_par = 0;
		chk("par_err", 4, pe);
		gnt_n = 1;
		req_valid = 1;
		cyc(6);
		chk("refused", 0, req_busy);
		chk("released", 0, {ad_oe, cbe_oe, par_oe});
		req_valid = 0;
		tgt_rdata = 32'h5a5a_a5a5; tgt_v = 1; tgt_rd_active = 1;
		cyc(2);
		chk("tgt rd", {1'b1, 32'h5a5a_a5a5}, {ad_oe, ad_out});
		chk("tgt trdy", 0, trdy_n);
		tgt_rd_active = 0; tgt_v = 0;
		cyc(1);
		chk("trdy rel", 2'b11, {trdy_oe, trdy_n_out});
		cyc(2);
		srst = 1;
		cyc(2);
		chk("oe rst2", 0, {ad_oe, par_oe, frame_oe, irdy_oe, trdy_oe});
		stop_test();
	end
endmodule : primary_pci_bus_interface_tb

// ---- pkg/ppi_par_if.sv ----
// ppi_par_if: carrier between sequencer and parity unit
// assumes: all signals on mclk
`timescale 1ns/1ns
interface ppi_par_if;
	logic [31:0] ad;
	logic [3:0]  cbe_n;
	logic        drive;
	logic        par;
	logic        par_oe;
	modport seq (output ad, output cbe_n, output drive, input par,
		input par_oe);
	modport par_unit (input ad, input cbe_n, input drive, output par,
		output par_oe);
endinterface : ppi_par_if

// ---- pkg/ppi_pkg.sv ----
// ppi_pkg: constants and types for the primary bus interface block
// assumes: one mclk domain, synchronous active-high reset
package ppi_pkg;
	localparam int         AD_W       = 32;
	localparam int         CBE_W      = 4;
	localparam logic [3:0] CMD_DUAL   = 4'hd;
	localparam logic [3:0] PARK_CMD   = 4'h0;
	localparam logic       DEASSERTED = 1'b1;
	typedef enum logic [2:0] {
		ppi_idle,
		ppi_park,
		ppi_addr,
		ppi_addr2,
		ppi_data,
		ppi_turn
	} ppi_state_t;
endpackage : ppi_pkg

// ---- src/ppi_parity.sv ----
// ppi_parity: registered even parity one cycle behind ad drive
// assumes: ad/cbe/drive are the values placed on the pins this cycle
`timescale 1ns/1ns
module ppi_parity (
	// clock and reset
	input  wire logic mclk,
	input  wire logic srst,
	// parity carrier
	ppi_par_if.par_unit pif
);
	logic next_par;
	logic next_oe;
	logic par_q;
	logic oe_q;

	always_comb begin
		next_par = ^{pif.ad, pif.cbe_n};
		next_oe  = pif.drive;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			par_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			par_q <= next_par;
			oe_q  <= next_oe;
		end
	end

	assign pif.par    = par_q;
	assign pif.par_oe = oe_q;

	a_par_even: assert property (@(posedge mclk) disable iff (srst)
		pif.drive |=> (pif.par == ^{$past(pif.ad), $past(pif.cbe_n)}))
		else $error("parity not even over ad and cbe");
	a_par_release: assert property (@(posedge mclk) disable iff (srst)
		$fell(pif.drive) |=> !pif.par_oe)
		else $error("parity not released one cycle after ad");
endmodule : ppi_parity

// ---- src/ppi_primary.sv ----
// ppi_primary: primary bus pin sequencer of the bridge
// assumes: pins pass through pad logic outside; inputs are bus-synchronous
`timescale 1ns/1ns
module ppi_primary (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// grant
	input  wire logic        gnt_n,
	// address/data pins
	input  wire logic [31:0] ad_in,
	output logic      [31:0] ad_out,
	output logic             ad_oe,
	input  wire logic [3:0]  cbe_n_in,
	output logic      [3:0]  cbe_n_out,
	output logic             cbe_oe,
	input  wire logic        par_in,
	output logic             par_out,
	output logic             par_oe,
	// handshake pins
	input  wire logic        frame_n_in,
	output logic             frame_n_out,
	output logic             frame_oe,
	input  wire logic        irdy_n_in,
	output logic             irdy_n_out,
	output logic             irdy_oe,
	input  wire logic        trdy_n_in,
	output logic             trdy_n_out,
	output logic             trdy_oe,
	// initiator request
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_dual,
	input  wire logic [3:0]  req_cmd,
	input  wire logic [63:0] req_addr,
	input  wire logic [7:0]  req_beats,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wbe_n,
	input  wire logic        wdata_valid,
	output logic             wdata_take,
	output logic             req_busy,
	output logic      [31:0] rdata,
	output logic             rdata_valid,
	// target read data supply
	input  wire logic        tgt_rd_active,
	input  wire logic [31:0] tgt_rdata,
	input  wire logic        tgt_rdata_valid,
	// parity check result
	output logic             par_err
);
	ppi_pkg::ppi_state_t state, next_state;
	logic [63:0] addr, next_addr;
	logic [7:0]  left, next_left;
	logic        wr, next_wr;
	logic [3:0]  cmd, next_cmd;
	logic        irdy, next_irdy;
	logic        frame_rel, next_frame_rel;
	logic        irdy_rel, next_irdy_rel;
	logic        trdy, next_trdy;
	logic        trdy_rel, next_trdy_rel;
	logic [31:0] ad_d, next_ad_d;
	logic [3:0]  cbe_d, next_cbe_d;
	logic        drv, next_drv;
	logic        check, next_check;
	logic [35:0] rx_q, next_rx_q;
	logic [31:0] rdq, next_rdq;
	logic        rdv, next_rdv;
	logic        perr, next_perr;
	logic        done;
	logic        last;

	ppi_par_if pif ();

	assign pif.ad    = ad_d;
	assign pif.cbe_n = cbe_d;
	assign pif.drive = drv;

	ppi_parity u_par (
		.mclk (mclk),
		.srst (srst),
		.pif  (pif)
	);

	// data phase completes when both ready signals are low
	assign done = !irdy_n_in && !trdy_n_in;
	assign last = (left == 8'h01);

	always_comb begin
		next_state     = state;
		next_addr      = addr;
		next_left      = left;
		next_wr        = wr;
		next_cmd       = cmd;
		next_irdy      = irdy;
		next_frame_rel = 1'b0;
		next_irdy_rel  = 1'b0;
		next_trdy      = 1'b0;
		next_trdy_rel  = 1'b0;
		next_ad_d      = ad_d;
		next_cbe_d     = cbe_d;
		next_drv       = 1'b0;
		next_check     = 1'b0;
		next_rdq       = rdq;
		next_rdv       = 1'b0;
		wdata_take     = 1'b0;
		case (state)
		ppi_pkg::ppi_idle, ppi_pkg::ppi_park: begin
			next_state = ppi_pkg::ppi_idle;
			if (!gnt_n && frame_n_in && irdy_n_in) begin
				if (req_valid) begin
					next_state = req_dual ? ppi_pkg::ppi_addr2
						: ppi_pkg::ppi_addr;
					next_addr  = req_addr;
					next_left  = req_beats;
					next_wr    = req_write;
					next_cmd   = req_cmd;
					next_ad_d  = req_addr[31:0];
					next_cbe_d = req_dual ? ppi_pkg::CMD_DUAL
						: req_cmd;
				end else begin
					next_state = ppi_pkg::ppi_park;
					next_ad_d  = '0;
					next_cbe_d = ppi_pkg::PARK_CMD;
				end
				next_drv = 1'b1;
			end
		end
		ppi_pkg::ppi_addr2: begin
			next_state = ppi_pkg::ppi_addr;
			next_ad_d  = addr[63:32];
			next_cbe_d = cmd;
			next_drv   = 1'b1;
		end
		ppi_pkg::ppi_addr: begin
			next_state = ppi_pkg::ppi_data;
			next_irdy  = !wr || wdata_valid;
			next_ad_d  = wdata;
			next_cbe_d = wbe_n;
			next_drv   = wr;
			wdata_take = wr && wdata_valid;
		end
		ppi_pkg::ppi_data: begin
			next_drv   = wr;
			next_cbe_d = cbe_d;
			if (!irdy && (!wr || wdata_valid)) begin
				next_irdy  = 1'b1;
				next_ad_d  = wdata;
				next_cbe_d = wbe_n;
				wdata_take = wr;
			end
			if (done) begin
				next_check = !wr;
				next_rdq   = ad_in;
				next_rdv   = !wr;
				next_left  = left - 8'h01;
				if (last) begin
					next_state     = ppi_pkg::ppi_turn;
					next_irdy      = 1'b0;
					next_frame_rel = 1'b1;
					next_irdy_rel  = 1'b1;
					next_drv       = 1'b0;
				end else begin
					next_irdy  = wr ? wdata_valid : 1'b1;
					next_ad_d  = wdata;
					next_cbe_d = wbe_n;
					wdata_take = wr && wdata_valid;
				end
			end
		end
		ppi_pkg::ppi_turn: begin
			next_state = ppi_pkg::ppi_idle;
		end
		default: next_state = ppi_pkg::ppi_idle;
		endcase
		// target read data, only while this device is the chosen target
		if (tgt_rd_active && state == ppi_pkg::ppi_idle) begin
			next_state = ppi_pkg::ppi_idle;
			next_drv   = 1'b1;
			next_ad_d  = tgt_rdata;
			next_trdy  = tgt_rdata_valid || (trdy && trdy_n_in == 1'b0
				&& irdy_n_in);
		end
		if (trdy && !next_trdy)
			next_trdy_rel = 1'b1;
		if (!frame_n_in && frame_n_in == 1'b0 && !trdy && state ==
			ppi_pkg::ppi_idle && !tgt_rd_active)
			next_check = 1'b1;
		next_rx_q = {ad_in, cbe_n_in};
		next_perr = check && (^{rx_q, par_in});
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state     <= ppi_pkg::ppi_idle;
			addr      <= '0;
			left      <= '0;
			wr        <= 1'b0;
			cmd       <= '0;
			irdy      <= 1'b0;
			frame_rel <= 1'b0;
			irdy_rel  <= 1'b0;
			trdy      <= 1'b0;
			trdy_rel  <= 1'b0;
			ad_d      <= '0;
			cbe_d     <= '0;
			drv       <= 1'b0;
			check     <= 1'b0;
			rx_q      <= '0;
			rdq       <= '0;
			rdv       <= 1'b0;
			perr      <= 1'b0;
		end else begin
			state     <= next_state;
			addr      <= next_addr;
			left      <= next_left;
			wr        <= next_wr;
			cmd       <= next_cmd;
			irdy      <= next_irdy;
			frame_rel <= next_frame_rel;
			irdy_rel  <= next_irdy_rel;
			trdy      <= next_trdy;
			trdy_rel  <= next_trdy_rel;
			ad_d      <= next_ad_d;
			cbe_d     <= next_cbe_d;
			drv       <= next_drv;
			check     <= next_check;
			rx_q      <= next_rx_q;
			rdq       <= next_rdq;
			rdv       <= next_rdv;
			perr      <= next_perr;
		end
	end

	logic own_init;
	assign own_init = state == ppi_pkg::ppi_addr
		|| state == ppi_pkg::ppi_addr2 || state == ppi_pkg::ppi_data;

	// pins: _n outputs are low when asserted
	assign ad_out      = ad_d;
	assign ad_oe       = drv;
	assign cbe_n_out   = cbe_d;
	assign cbe_oe      = drv || own_init || state == ppi_pkg::ppi_park;
	assign par_out     = pif.par;
	assign par_oe      = pif.par_oe;
	// frame low until the final phase; high through that phase, then one more cycle
	assign frame_n_out = frame_rel ? ppi_pkg::DEASSERTED
		: !(own_init && !(state == ppi_pkg::ppi_data && last && irdy));
	assign frame_oe    = own_init || frame_rel;
	assign irdy_n_out  = irdy_rel ? ppi_pkg::DEASSERTED : !irdy;
	assign irdy_oe     = state == ppi_pkg::ppi_data || irdy_rel;
	assign trdy_n_out  = trdy_rel ? ppi_pkg::DEASSERTED : !trdy;
	assign trdy_oe     = trdy || trdy_rel;
	assign req_busy    = state != ppi_pkg::ppi_idle
		&& state != ppi_pkg::ppi_park;
	assign rdata       = rdq;
	assign rdata_valid = rdv;
	assign par_err     = perr;

	a_park_drive: assert property (@(posedge mclk) disable iff (srst)
		(state == ppi_pkg::ppi_park) |-> ad_oe && cbe_oe)
		else $error("parked bus not driven");
	a_park_par: assert property (@(posedge mclk) disable iff (srst)
		$rose(ad_oe) |=> par_oe)
		else $error("parity not driven after ad");
	a_irdy_hold: assert property (@(posedge mclk) disable iff (srst)
		(irdy_oe && !irdy_n_out && trdy_n_in) |=> !irdy_n_out)
		else $error("initiator ready dropped early");
	a_frame_pulse: assert property (@(posedge mclk) disable iff (srst)
		frame_rel |-> frame_oe && frame_n_out ##1 !frame_rel)
		else $error("frame release pulse wrong");
	a_trdy_pulse: assert property (@(posedge mclk) disable iff (srst)
		trdy_rel |-> trdy_oe && trdy_n_out)
		else $error("target ready release not high");
	a_no_drive_idle: assert property (@(posedge mclk) disable iff (srst)
		(state == ppi_pkg::ppi_idle && !tgt_rd_active && gnt_n)
		|=> !ad_oe || state != ppi_pkg::ppi_idle)
		else $error("ad driven without ownership");
	c_park: cover property (@(posedge mclk) state == ppi_pkg::ppi_park);
	c_dual: cover property (@(posedge mclk) state == ppi_pkg::ppi_addr2);
	c_last: cover property (@(posedge mclk) frame_rel);
	c_perr: cover property (@(posedge mclk) par_err);
endmodule : ppi_primary
